// ---- asrp_pkg.sv ----
// shared constants and types for the serial result port
package asrp_pkg;

    // result word and buffering
    localparam int RESULT_W   = 16;
    localparam int FIFO_DEPTH = 16;

    // bits per serial frame, one result per frame
    localparam logic [4:0] BITS_PER_FRAME = 5'h10;
    localparam logic [4:0] LAST_BIT       = 5'h0F;

    // system clock
    localparam int CLK_PERIOD_NS = 100;

    // generated bit clock periods; read-during-convert runs slower
    localparam int MST_BIT_RAC_NS = 400;
    localparam int MST_BIT_RDC_NS = 800;

    // quarter bit period in clock cycles, rounded down, at least one
    localparam int MST_QTR_RAC_INT = (MST_BIT_RAC_NS < 4 * CLK_PERIOD_NS) ? 1 :
                                     MST_BIT_RAC_NS / (4 * CLK_PERIOD_NS);
    localparam int MST_QTR_RDC_INT = (MST_BIT_RDC_NS < 4 * CLK_PERIOD_NS) ? 1 :
                                     MST_BIT_RDC_NS / (4 * CLK_PERIOD_NS);
    localparam logic [2:0] MST_QTR_RAC = 3'(MST_QTR_RAC_INT);
    localparam logic [2:0] MST_QTR_RDC = 3'(MST_QTR_RDC_INT);

    // positions of the sampled pins in the synchroniser vector
    localparam int PIN_CS_B     = 0;
    localparam int PIN_RD_B     = 1;
    localparam int PIN_SCLK     = 2;
    localparam int PIN_MODE     = 3;
    localparam int PIN_PTYPE    = 4;
    localparam int PIN_CLKSRC   = 5;
    localparam int PIN_CLKPOL   = 6;
    localparam int PIN_FMPOL    = 7;
    localparam int PIN_CODING   = 8;
    localparam int PIN_NUM      = 9;

    // pin reset values: selects deasserted, everything else low
    localparam logic [8:0] PIN_RST = 9'h003;

    // reset values
    localparam logic [15:0] WORD_RST = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MASTER,
        ST_SLAVE,
        ST_WAIT
    } asrp_state_e;

endpackage : asrp_pkg

// ---- asrp_fifo_if.sv ----
// valid/ready carrier between the port logic and its result buffer
`timescale 1ns/1ps
interface asrp_fifo_if #(
    parameter int W = 16
);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;

    modport fifo_side (
        input  push_valid,
        output push_ready,
        input  push_data,
        output pop_valid,
        input  pop_ready,
        output pop_data
    );

    modport user_side (
        output push_valid,
        input  push_ready,
        output push_data,
        input  pop_valid,
        output pop_ready,
        input  pop_data
    );
endinterface : asrp_fifo_if

// ---- asrp_fifo.sv ----
// result buffer with valid and ready on both sides
`timescale 1ns/1ps
module asrp_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    asrp_fifo_if.fifo_side   f
);
    localparam int PW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0]       wr_ptr;
        logic [PW-1:0]       rd_ptr;
        logic [PW:0]         count;
    } asrp_fifo_s;

    asrp_fifo_s q;
    asrp_fifo_s d;
    logic       do_push;
    logic       do_pop;

    // full and empty come straight from the count flop
    assign f.push_ready = (q.count != (PW+1)'(D));
    assign f.pop_valid  = (q.count != '0);
    assign f.pop_data   = q.mem[q.rd_ptr];

    always_comb begin
        d       = q;
        do_push = f.push_valid && f.push_ready;
        do_pop  = f.pop_ready && f.pop_valid;
        if (do_push) begin
            d.mem[q.wr_ptr] = f.push_data;
            d.wr_ptr        = (q.wr_ptr == PW'(D - 1)) ? '0 : q.wr_ptr + 1'b1;
        end
        if (do_pop) begin
            d.rd_ptr = (q.rd_ptr == PW'(D - 1)) ? '0 : q.rd_ptr + 1'b1;
        end
        if (do_push && !do_pop) begin
            d.count = q.count + 1'b1;
        end else if (do_pop && !do_push) begin
            d.count = q.count - 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : asrp_fifo

// ---- asrp_port.sv ----
// serial result port of a 16-bit sampling converter, shared with the parallel bus
// Summary of operation
// [RL1] port type select high: pins act as serial port; low: parallel bits.
// [RL2] master, read-during-convert high: previous result shifts during conversion, slower clock.
// [RL3] master, read-during-convert low: current result shifts only after conversion ends.
// [RL4] slave: daisy-chain level appears on serial output 16 bit clocks after start.
// [RL5] results leave the shift register most significant bit first.
// [RL6] serial coding follows the output coding select level.
// [RL7] master: each output bit stable across both generated clock edges.
// [RL8] slave, clock polarity low: output changes on rising edge.
// [RL9] slave, clock polarity high: output changes on falling edge.
// [RL10] bit clock pin is output in master, input in slave.
// [RL11] master, marker polarity low: frame marker high while bits are valid.
// [RL12] master, marker polarity high: frame marker low while bits are valid.
// [RL13] clock source low: device is master; high: slave on gated host clock.
// [RL14] clock polarity select inverts bit clock sense in every serial mode.
// [RL15] coding high: straight binary; low: most significant bit inverted.
// [RL16] slave: conversion ending mid-read discards data and pulses incomplete read flag.
// [RL17] one 16-bit result per frame; marker goes inactive after last bit.
`timescale 1ns/1ps
module asrp_port (
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    input  wire logic        i_port_type_select,
    input  wire logic        i_clock_source_select,
    input  wire logic        i_clock_polarity_select,
    input  wire logic        i_frame_marker_polarity_select,
    input  wire logic        i_output_coding_select,
    input  wire logic        i_read_during_convert_select,
    input  wire logic        i_cs_b,
    input  wire logic        i_rd_b,
    input  wire logic        i_bit_clock,
    input  wire logic [15:0] i_result,
    input  wire logic        i_result_valid,
    input  wire logic        i_converting,
    output logic             o_result_ready,
    output logic             o_bit_clock,
    output logic             o_bit_clock_oe,
    output logic             o_serial_result_output,
    output logic             o_serial_result_output_oe,
    output logic             o_frame_marker,
    output logic             o_frame_marker_oe,
    output logic             o_incomplete_read_flag,
    output logic [15:0]      o_parallel_data,
    output logic             o_parallel_data_oe
);

    typedef struct packed {
        logic [8:0]             s1;
        logic [8:0]             s2;
        logic [8:0]             s3;
        logic [8:0]             filt;
        logic                   rd_on_prev;
        asrp_pkg::asrp_state_e  state;
        logic [15:0]            sr;
        logic [4:0]             bitcnt;
        logic [4:0]             phase;
        logic [2:0]             qtr;
        logic                   mclk;
        logic                   fm_act;
        logic                   sclk_o;
        logic                   sclk_oe;
        logic                   sd_oe;
        logic                   fm_o;
        logic                   fm_oe;
        logic                   err;
        logic [15:0]            par;
        logic                   par_oe;
        logic                   rdy;
    } asrp_port_s;

    asrp_port_s q;
    asrp_port_s d;

    asrp_fifo_if #(.W(asrp_pkg::RESULT_W)) fifo_bus ();

    asrp_fifo #(
        .W (asrp_pkg::RESULT_W),
        .D (asrp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .f       (fifo_bus.fifo_side)
    );

    logic [8:0]  pins;
    logic        rd_on;
    logic        serial;
    logic        master;
    logic        read_during_convert_select;
    logic        daisy;
    logic        clkpol;
    logic        pushed;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        upd;
    logic        pop;
    logic [15:0] coded;
    logic [4:0]  per;
    logic [4:0]  hi_end;
    logic [4:0]  np;

    // all pins are asynchronous to i_clock and pass three flops
    always_comb begin
        pins                        = '0;
        pins[asrp_pkg::PIN_CS_B]   = i_cs_b;
        pins[asrp_pkg::PIN_RD_B]   = i_rd_b;
        pins[asrp_pkg::PIN_SCLK]   = i_bit_clock;
        pins[asrp_pkg::PIN_MODE]   = i_read_during_convert_select;
        pins[asrp_pkg::PIN_PTYPE]  = i_port_type_select;
        pins[asrp_pkg::PIN_CLKSRC] = i_clock_source_select;
        pins[asrp_pkg::PIN_CLKPOL] = i_clock_polarity_select;
        pins[asrp_pkg::PIN_FMPOL]  = i_frame_marker_polarity_select;
        pins[asrp_pkg::PIN_CODING] = i_output_coding_select;
    end

    assign fifo_bus.push_valid = i_result_valid;
    assign fifo_bus.push_data  = i_result;
    assign fifo_bus.pop_ready  = pop;

    always_comb begin
        d    = q;
        pop  = 1'b0;
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // a pin change counts once the second and third stages agree
        for (int i = 0; i < asrp_pkg::PIN_NUM; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.filt[i] = q.s3[i];
            end
        end

        rd_on     = !q.filt[asrp_pkg::PIN_CS_B] && !q.filt[asrp_pkg::PIN_RD_B];
        serial    = q.filt[asrp_pkg::PIN_PTYPE];                           // [RL1]
        master    = !q.filt[asrp_pkg::PIN_CLKSRC];                         // [RL13]
        read_during_convert_select       = q.filt[asrp_pkg::PIN_MODE];
        daisy     = q.filt[asrp_pkg::PIN_MODE];
        clkpol    = q.filt[asrp_pkg::PIN_CLKPOL];
        pushed    = i_result_valid && fifo_bus.push_ready;
        // edge taken as the filter flips: one cycle less lag inside a host half period
        sclk_rise = q.s2[asrp_pkg::PIN_SCLK] && q.s3[asrp_pkg::PIN_SCLK]
                    && !q.filt[asrp_pkg::PIN_SCLK];
        sclk_fall = !q.s2[asrp_pkg::PIN_SCLK] && !q.s3[asrp_pkg::PIN_SCLK]
                    && q.filt[asrp_pkg::PIN_SCLK];
        upd       = clkpol ? sclk_fall : sclk_rise;                        // [RL8] [RL9]

        // straight binary or msb inverted for two's complement
        coded = q.filt[asrp_pkg::PIN_CODING] ? fifo_bus.pop_data :
                {~fifo_bus.pop_data[15], fifo_bus.pop_data[14:0]};          // [RL6] [RL15]

        // master bit: low quarter, two high quarters, low quarter
        per    = {q.qtr, 2'b00};
        hi_end = per - {2'b00, q.qtr};
        np     = (q.phase == per - 5'h01) ? 5'h00 : q.phase + 5'h01;

        d.rd_on_prev = rd_on;
        d.err        = 1'b0;

        case (q.state)
            asrp_pkg::ST_IDLE: begin
                d.fm_act = 1'b0;
                d.mclk   = 1'b0;
                d.bitcnt = 5'h00;
                d.phase  = 5'h00;
                if (serial && rd_on && fifo_bus.pop_valid) begin
                    if (master) begin
                        // after-convert reads wait for the conversion to end
                        if (read_during_convert_select || !i_converting) begin                    // [RL2] [RL3]
                            pop      = 1'b1;
                            d.sr     = coded;                               // [RL5]
                            d.qtr    = read_during_convert_select ? asrp_pkg::MST_QTR_RDC :
                                             asrp_pkg::MST_QTR_RAC;         // [RL2]
                            d.fm_act = 1'b1;                                // [RL11] [RL12]
                            d.state  = asrp_pkg::ST_MASTER;
                        end
                    end else begin
                        pop     = 1'b1;
                        d.sr    = coded;                                    // [RL5]
                        d.state = asrp_pkg::ST_SLAVE;
                    end
                end
            end
            asrp_pkg::ST_MASTER: begin
                d.phase = np;
                // data moves only at the bit start, away from both edges
                d.mclk  = (np >= {2'b00, q.qtr}) && (np < hi_end);         // [RL7]
                if (np == 5'h00) begin
                    if (q.bitcnt == asrp_pkg::LAST_BIT) begin
                        d.fm_act = 1'b0;                                    // [RL17]
                        d.mclk   = 1'b0;
                        d.state  = asrp_pkg::ST_WAIT;
                    end else begin
                        d.sr     = {q.sr[14:0], 1'b0};                      // [RL5]
                        d.bitcnt = q.bitcnt + 5'h01;
                    end
                end
                if (!serial || !master) begin
                    d.fm_act = 1'b0;
                    d.mclk   = 1'b0;
                    d.state  = asrp_pkg::ST_IDLE;
                end
            end
            asrp_pkg::ST_SLAVE: begin
                // the host clock only counts while the port is selected
                if (!rd_on || !serial || master) begin
                    d.state = asrp_pkg::ST_IDLE;
                end else begin
                    if (upd) begin
                        d.sr = {q.sr[14:0], daisy};                        // [RL4]
                        if (q.bitcnt != asrp_pkg::BITS_PER_FRAME) begin
                            d.bitcnt = q.bitcnt + 5'h01;
                        end
                    end
                    // a result landing mid-read kills the read in progress
                    if (pushed && (q.bitcnt != asrp_pkg::BITS_PER_FRAME)) begin
                        d.err   = 1'b1;                                     // [RL16]
                        d.sr    = asrp_pkg::WORD_RST;
                        d.state = asrp_pkg::ST_WAIT;
                    end
                end
            end
            asrp_pkg::ST_WAIT: begin
                // one result per selection; deselect to start another
                d.fm_act = 1'b0;
                d.mclk   = 1'b0;
                if (!rd_on) begin
                    d.state = asrp_pkg::ST_IDLE;                            // [RL17]
                end
            end
            default: begin
                d.state = asrp_pkg::ST_IDLE;
            end
        endcase

        // parallel reads drain one result per read strobe
        if (!serial && q.rd_on_prev && !rd_on && fifo_bus.pop_valid) begin
            pop = 1'b1;                                                     // [RL1]
        end

        d.sclk_o  = d.mclk ^ clkpol;                                        // [RL14]
        d.sclk_oe = serial && master;                                       // [RL10]
        d.fm_o    = d.fm_act ^ q.filt[asrp_pkg::PIN_FMPOL];                 // [RL11] [RL12]
        d.fm_oe   = serial && master;
        d.sd_oe   = serial && rd_on;                                        // [RL1]
        d.par     = coded;
        d.par_oe  = !serial && rd_on;                                       // [RL1]
        d.rdy     = fifo_bus.push_ready;
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q            <= '0;
            q.s1         <= asrp_pkg::PIN_RST;
            q.s2         <= asrp_pkg::PIN_RST;
            q.s3         <= asrp_pkg::PIN_RST;
            q.filt       <= asrp_pkg::PIN_RST;
            q.state      <= asrp_pkg::ST_IDLE;
            q.sr         <= asrp_pkg::WORD_RST;
            q.par        <= asrp_pkg::WORD_RST;
            q.qtr        <= asrp_pkg::MST_QTR_RAC;
            q.rdy        <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // every output is a flop of the state struct
    assign o_result_ready            = q.rdy;
    assign o_bit_clock               = q.sclk_o;
    assign o_bit_clock_oe            = q.sclk_oe;
    assign o_serial_result_output    = q.sr[15];
    assign o_serial_result_output_oe = q.sd_oe;
    assign o_frame_marker            = q.fm_o;
    assign o_frame_marker_oe         = q.fm_oe;
    assign o_incomplete_read_flag    = q.err;
    assign o_parallel_data           = q.par;
    assign o_parallel_data_oe        = q.par_oe;

endmodule : asrp_port

// ---- asrp_port_props.sv ----
// concurrent checks on the serial result port pins
`timescale 1ns/1ps
module asrp_port_props (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_clock_polarity_select,
    input wire logic i_frame_marker_polarity_select,
    input wire logic i_read_during_convert_select,
    input wire logic i_converting,
    input wire logic o_bit_clock,
    input wire logic o_bit_clock_oe,
    input wire logic o_serial_result_output,
    input wire logic o_serial_result_output_oe,
    input wire logic o_frame_marker,
    input wire logic o_frame_marker_oe,
    input wire logic o_incomplete_read_flag,
    input wire logic o_parallel_data_oe
);
    logic       act;
    logic       gen;
    logic       gen_q;
    logic [7:0] act_cnt_q;
    logic [4:0] edge_cnt_q;

    // polarity pins raw, so they must only move outside master frames
    assign act = o_frame_marker_oe & (o_frame_marker ^ i_frame_marker_polarity_select);
    assign gen = o_bit_clock ^ i_clock_polarity_select;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gen_q      <= 1'b0;
            act_cnt_q  <= 8'h00;
            edge_cnt_q <= 5'h00;
        end else begin
            gen_q      <= gen;
            act_cnt_q  <= act ? act_cnt_q + 8'h01 : 8'h00;
            edge_cnt_q <= act ? edge_cnt_q + {4'h0, gen & ~gen_q} : 5'h00;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    sequence s_hi_fast; gen [*2] ##1 !gen; endsequence
    sequence s_hi_slow; gen [*4] ##1 !gen; endsequence

    property p_hi_slow; act && $rose(gen) && i_read_during_convert_select |-> s_hi_slow; endproperty
    property p_hi_fast; act && $rose(gen) && !i_read_during_convert_select |-> s_hi_fast; endproperty
    property p_rac_start; $rose(act) && !i_read_during_convert_select |-> $past(!i_converting);
    endproperty
    property p_frame_len; $fell(act) |-> (act_cnt_q == 8'h40 || act_cnt_q == 8'h80); endproperty
    property p_frame_bits; $fell(act) |-> edge_cnt_q == 5'h10; endproperty
    property p_serial_result_output_stable; act && $changed(o_bit_clock) |-> $stable(o_serial_result_output);
    endproperty
    property p_idle_level; o_bit_clock_oe && !act |-> o_bit_clock == i_clock_polarity_select;
    endproperty
    property p_oe_pair; o_frame_marker_oe == o_bit_clock_oe; endproperty
    property p_oe_excl; o_parallel_data_oe |-> !o_serial_result_output_oe && !o_bit_clock_oe;
    endproperty
    property p_flag_pulse; o_incomplete_read_flag |-> !o_bit_clock_oe ##1 !o_incomplete_read_flag;
    endproperty

    a_hi_slow: assert property (p_hi_slow) else $error("slow bit clock high width wrong");
    a_hi_fast: assert property (p_hi_fast) else $error("fast bit clock high width wrong");
    a_rac_start: assert property (p_rac_start) else $error("frame began during conversion");
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
    a_frame_bits: assert property (p_frame_bits) else $error("frame bit count wrong");
    a_serial_result_output_stable: assert property (p_serial_result_output_stable) else $error("data moved on clock edge");
    a_idle_level: assert property (p_idle_level) else $error("idle clock level wrong");
    a_oe_pair: assert property (p_oe_pair) else $error("clock and marker drive differ");
    a_oe_excl: assert property (p_oe_excl) else $error("serial and parallel both driven");
    a_flag_pulse: assert property (p_flag_pulse) else $error("read flag not one pulse");
endmodule : asrp_port_props

bind asrp_port asrp_port_props u_asrp_port_props (.*);

// ---- asrp_host_model.sv ----
// host side model: slave bit clock source and result capture
`timescale 1ns/1ps
module asrp_host_model (
    input  wire logic       i_slave,
    input  wire logic       i_pol,
    input  wire logic       i_marker_pol,
    input  wire logic       i_go,
    input  wire logic [4:0] i_edges,
    input  wire logic       i_pin_clock,
    input  wire logic       i_serial_result_output,
    input  wire logic       i_marker,
    output logic            o_bit_clock,
    output logic [16:0]     o_word,
    output logic [5:0]      o_count
);
    localparam int HALF_NS = 400;
    logic busy;

    initial begin
        o_bit_clock = 1'b1;
        busy = 1'b0;
        o_word = 17'h00000;
        o_count = 6'h00;
    end

    // clock stands still between frames
    always @(i_pol) if (!busy) o_bit_clock = ~i_pol;

    always @(posedge i_go) begin
        o_word = 17'h00000;
        o_count = 6'h00;
        if (i_slave) begin
            busy = 1'b1;
            for (int k = 0; k < 32'(i_edges); k++) begin
                #(HALF_NS) o_bit_clock = i_pol;
                o_word = {o_word[15:0], i_serial_result_output};
                o_count = o_count + 6'h01;
                #(HALF_NS) o_bit_clock = ~i_pol;
            end
            busy = 1'b0;
        end
    end

    // master: take bits only on the active edge inside the marker
    always @(i_pin_clock) begin
        if (!i_slave && (i_pin_clock ^ i_pol) && (i_marker ^ i_marker_pol)) begin
            o_word = {o_word[15:0], i_serial_result_output};
            o_count = o_count + 6'h01;
        end
    end
endmodule : asrp_host_model

// ---- asrp_port_tb_top.sv ----
// self-checking bench for the serial result port
`timescale 1ns/1ps
module asrp_port_tb_top;
    logic i_clock, i_rst_b, i_port_type_select, i_clock_source_select;
    logic i_clock_polarity_select, i_frame_marker_polarity_select, i_output_coding_select;
    logic i_read_during_convert_select, i_cs_b, i_rd_b, i_result_valid, i_converting;
    logic [15:0] i_result, o_parallel_data;
    logic o_result_ready, o_bit_clock, o_bit_clock_oe, o_serial_result_output;
    logic o_serial_result_output_oe, o_frame_marker, o_frame_marker_oe;
    logic o_incomplete_read_flag, o_parallel_data_oe, host_clk, go;
    logic [4:0]  edges;
    logic [16:0] cap_word;
    logic [5:0]  cap_count;
    wire         pin_clock;
    int          n_mismatch, total_checks, cyc, flags, k;
    logic [15:0] exp_q[$];

    assign pin_clock = o_bit_clock_oe ? o_bit_clock : host_clk;

    asrp_port u_asrp_port (.i_bit_clock(pin_clock), .*);
    asrp_host_model u_asrp_host_model (.i_slave(i_clock_source_select),
        .i_pol(i_clock_polarity_select), .i_marker_pol(i_frame_marker_polarity_select),
        .i_go(go), .i_edges(edges), .i_pin_clock(pin_clock), .i_serial_result_output(o_serial_result_output),
        .i_marker(o_frame_marker), .o_bit_clock(host_clk), .o_word(cap_word),
        .o_count(cap_count));

    initial i_clock = 1'b0;
    always #50 i_clock = ~i_clock;

    // ceiling well above the few thousand cycles the run needs
    always @(posedge i_clock) begin
        cyc++;
        if (o_incomplete_read_flag === 1'b1) flags++;
        if (cyc == 20000) begin
            n_mismatch++;
            $display("BAD %0t run did not end in time", $time);
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #10;
    endtask : tick

    task automatic push(input logic [15:0] w);
        i_result = w;
        i_result_valid = 1'b1;
        tick(1);
        i_result_valid = 1'b0;
        tick(1);
        exp_q.push_back(w);
    endtask : push

    // coding is applied when the word leaves the buffer
    function automatic logic [15:0] pop_exp();
        logic [15:0] w;
        w = exp_q.pop_front();
        return i_output_coding_select ? w : w ^ 16'h8000;
    endfunction : pop_exp

    task automatic sel(input logic s);
        i_cs_b = ~s;
        i_rd_b = ~s;
    endtask : sel

    task automatic host(input logic [4:0] n);
        edges = n;
        go = 1'b1;
        tick(1);
        go = 1'b0;
    endtask : host

    task automatic wait_bits(input logic [5:0] n);
        int t;
        t = 0;
        while (cap_count < n && t < 3000) begin
            tick(1);
            t++;
        end
    endtask : wait_bits

    // polarity pins move only in slave mode, outside any frame
    task automatic set_mode(input logic src, input logic pol, input logic mpol);
        i_clock_source_select = 1'b1;
        tick(8);
        i_clock_polarity_select = pol;
        i_frame_marker_polarity_select = mpol;
        tick(8);
        i_clock_source_select = src;
        tick(8);
    endtask : set_mode

    task automatic master_read();
        logic [15:0] e;
        e = pop_exp();
        host(5'h00);
        sel(1'b1);
        wait_bits(6'h10);
        tick(150);
        check(cap_word, {1'b0, e});
        check({11'h000, cap_count}, 17'h00010);
        sel(1'b0);
        tick(10);
    endtask : master_read

    task automatic slave_read(input logic daisy);
        logic [15:0] e;
        e = pop_exp();
        i_read_during_convert_select = daisy;
        sel(1'b1);
        tick(20);
        host(5'h11);
        wait_bits(6'h11);
        tick(10);
        check(cap_word, {e, daisy});
        sel(1'b0);
        tick(10);
    endtask : slave_read

    initial begin
        {i_rst_b, i_clock_source_select, i_clock_polarity_select, i_converting} = 4'h0;
        {i_frame_marker_polarity_select, i_read_during_convert_select, go} = 3'h0;
        {i_port_type_select, i_output_coding_select, i_cs_b, i_rd_b} = 4'hF;
        {i_result_valid, i_result, edges} = 22'h000000;
        tick(16);
        i_rst_b = 1'b1;
        tick(8);
        foreach (exp_q[j]) k = j;
        for (k = 0; k < 8; k++) push(16'hA5C3 ^ (16'h1111 * 16'(k)));
        master_read();
        i_output_coding_select = 1'b0;
        tick(8);
        master_read();
        i_output_coding_select = 1'b1;
        set_mode(1'b0, 1'b1, 1'b1);
        master_read();
        {i_read_during_convert_select, i_converting} = 2'h3;
        tick(8);
        master_read();
        i_read_during_convert_select = 1'b0;
        tick(8);
        host(5'h00);
        sel(1'b1);
        tick(100);
        check({11'h000, cap_count}, 17'h00000);
        sel(1'b0);
        tick(8);
        i_converting = 1'b0;
        tick(8);
        master_read();
        set_mode(1'b1, 1'b0, 1'b0);
        slave_read(1'b1);
        set_mode(1'b1, 1'b1, 1'b0);
        slave_read(1'b0);
        void'(pop_exp());
        sel(1'b1);
        tick(20);
        host(5'h04);
        tick(20);
        push(16'h5AA5);
        tick(30);
        check(17'(flags), 17'h00001);
        sel(1'b0);
        tick(10);
        for (k = 0; k < 40 && o_result_ready === 1'b1; k++) push(16'h0100 + 16'(k));
        check(17'(exp_q.size()), 17'h00010);
        i_port_type_select = 1'b0;
        tick(8);
        while (exp_q.size() > 0) begin
            sel(1'b1);
            tick(8);
            check({o_parallel_data_oe, o_parallel_data}, {1'b1, pop_exp()});
            sel(1'b0);
            tick(8);
        end
        check({16'h0000, o_result_ready}, 17'h00001);
        finish_test();
    end
endmodule : asrp_port_tb_top
